//--- verilog/tcap_pkg.sv
// What this block does
// - center-aligned mode counts up from zero to modulus, down to zero, repeat.
// - zero and terminal count each last one clock in center-aligned mode.
// - level interrupt while overflow flag set and enable high; none otherwise.
// - up mode without modulus wraps all-ones to zero, setting overflow flag.
// - up mode with modulus wraps modulus to zero, setting overflow flag.
// - up/down mode sets overflow flag when turning down from modulus.
// - reading either counter byte snapshots both until both bytes are read.
// - writing either counter byte zeroes counter and clears read snapshot state.
// - with center-aligned off, mode bits 00 select capture; any other mode value disables it.
// - active capture edge copies counter into channel value register.
// - capture edge selectable: rising, falling or either.
// - capture value reads latch both bytes; status write resets that sequence.
// - capture sets channel event flag, optional channel interrupt request.
package tcap_pkg;
  localparam int          NCH            = 2;
  localparam logic [15:0] CNT_ALL_ONES   = 16'hffff;
  localparam logic [15:0] CNT_ZERO       = 16'h0000;
  // register byte addresses, one 32-bit word each
  localparam logic [7:0]  A_STATUS_CTRL  = 8'h00;
  localparam logic [7:0]  A_COUNT_HI     = 8'h04;
  localparam logic [7:0]  A_COUNT_LO     = 8'h08;
  localparam logic [7:0]  A_MOD_HI       = 8'h0c;
  localparam logic [7:0]  A_MOD_LO       = 8'h10;
  localparam logic [7:0]  A_CH_BASE      = 8'h20;
  localparam logic [7:0]  A_CH_STRIDE    = 8'h10;
  localparam logic [7:0]  A_CH_SC        = 8'h00;
  localparam logic [7:0]  A_CH_VAL_HI    = 8'h04;
  localparam logic [7:0]  A_CH_VAL_LO    = 8'h08;
  // status/control field positions
  localparam int          B_TOF          = 7;
  localparam int          B_OVERFLOW_IRQ_ENABLE         = 6;
  localparam int          B_CENTER_ALIGNED_SELECT        = 5;
  // channel status/control field positions
  localparam int          B_CHF          = 7;
  localparam int          B_CHIE         = 6;
  localparam int          B_MSB          = 5;
  localparam int          B_MSA          = 4;
  localparam int          B_ELSB         = 3;
  localparam int          B_ELSA         = 2;
  localparam logic [7:0]  SC_RESET       = 8'h00;
  localparam logic [15:0] MOD_RESET      = 16'h0000;
  // channel mode from mode bits
  typedef enum logic [1:0] {
    TC_MODE_CAPTURE = 2'b00,
    TC_MODE_COMPARE = 2'b01,
    TC_MODE_PWM     = 2'b10,
    TC_MODE_PWM2    = 2'b11
  } tc_mode_e;
endpackage : tcap_pkg

//--- verilog/tcap_timer.sv
`timescale 1ns/1ps
`default_nettype none
module tcap_timer (
  input  wire logic                      clk_in,
  input  wire logic                      reset_in,
  input  wire logic [7:0]                paddr_in,
  input  wire logic                      psel_in,
  input  wire logic                      penable_in,
  input  wire logic                      pwrite_in,
  input  wire logic [31:0]               pwdata_in,
  output logic      [31:0]               prdata_out,
  output logic                           pready_out,
  output logic                           pslverr_out,
  input  wire logic [tcap_pkg::NCH-1:0]  event_pin_in,
  output logic                           overflow_irq_out,
  output logic      [tcap_pkg::NCH-1:0]  channel_irq_out,
  output logic      [15:0]               count_out
);
  import tcap_pkg::*;

  // decoded bus strobes
  logic       acc;
  logic       wr;
  logic       rd;

  // writes commit at the access edge, when the transfer completes
  assign acc = psel_in && penable_in;
  assign wr  = acc && pwrite_in;

  // read side effects sit at the setup edge, where the answer byte is
  // latched, so a snapshot always holds the very count handed out;
  // moving them to the access edge would buffer a count one step later
  assign rd  = psel_in && !penable_in && !pwrite_in;

  // channel address decode, used for every channel register
  function automatic logic ch_hit(input logic [7:0] a, input int n,
                                  input logic [7:0] reg_off);
    ch_hit = (a == 8'(A_CH_BASE + A_CH_STRIDE * n + reg_off));
  endfunction : ch_hit

  // counter state: control byte, count, modulus, direction and the
  // read snapshot with its two byte-read markers
  logic [7:0]  sc_r, sc_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [15:0] mod_r, mod_nxt;
  logic        down_r, down_nxt;
  logic [15:0] cbuf_r, cbuf_nxt;
  logic        clk_hi_r, clk_hi_nxt;
  logic        clk_lo_r, clk_lo_nxt;
  logic        ovf_ev;
  logic        cnt_wr;
  logic        center_aligned_select;
  logic [15:0] term;

  // mode select and terminal count; modulus zero means all ones
  assign center_aligned_select  = sc_r[B_CENTER_ALIGNED_SELECT];
  assign term   = (mod_r == MOD_RESET) ? CNT_ALL_ONES : mod_r;
  assign cnt_wr = wr && (paddr_in == A_COUNT_HI || paddr_in == A_COUNT_LO);

  // counting, modulus, overflow and counter coherency
  always_comb begin
    cnt_nxt    = cnt_r;
    down_nxt   = down_r;
    ovf_ev     = 1'b0;
    mod_nxt    = mod_r;
    sc_nxt     = sc_r;
    cbuf_nxt   = cbuf_r;
    clk_hi_nxt = clk_hi_r;
    clk_lo_nxt = clk_lo_r;

    // center-aligned: up to term, step down to zero, then back up from zero
    if (center_aligned_select) begin
      if (!down_r) begin
        if (cnt_r >= term) begin
          down_nxt = 1'b1;
          cnt_nxt  = cnt_r - 16'h0001;
          ovf_ev   = 1'b1;
        end else begin
          cnt_nxt = cnt_r + 16'h0001;
        end
      end else begin
        if (cnt_r == CNT_ZERO) begin
          down_nxt = 1'b0;
          cnt_nxt  = cnt_r + 16'h0001;
        end else begin
          cnt_nxt = cnt_r - 16'h0001;
        end
      end
    end else begin
      // up counting: wrap to zero after the terminal count
      down_nxt = 1'b0;
      if (cnt_r >= term) begin
        cnt_nxt = CNT_ZERO;
        ovf_ev  = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 16'h0001;
      end
    end

    // snapshot on first read of either byte; the buffer then answers
    // both byte reads until the pair is complete, while counting goes on
    if (rd && paddr_in == A_COUNT_HI) begin
      if (!clk_hi_r && !clk_lo_r) cbuf_nxt = cnt_r;
      clk_hi_nxt = 1'b1;
    end
    if (rd && paddr_in == A_COUNT_LO) begin
      if (!clk_hi_r && !clk_lo_r) cbuf_nxt = cnt_r;
      clk_lo_nxt = 1'b1;
    end
    if (clk_hi_nxt && clk_lo_nxt) begin
      clk_hi_nxt = 1'b0;
      clk_lo_nxt = 1'b0;
    end

    // any write to a count byte restarts from zero
    if (cnt_wr) begin
      cnt_nxt    = CNT_ZERO;
      down_nxt   = 1'b0;
      clk_hi_nxt = 1'b0;
      clk_lo_nxt = 1'b0;
    end

    // modulus bytes; zero leaves the counter free running
    if (wr && paddr_in == A_MOD_HI) mod_nxt[15:8] = pwdata_in[7:0];
    if (wr && paddr_in == A_MOD_LO) mod_nxt[7:0]  = pwdata_in[7:0];

    // control bits; flag cleared by writing zero, set wins
    if (wr && paddr_in == A_STATUS_CTRL) begin
      sc_nxt[B_OVERFLOW_IRQ_ENABLE]  = pwdata_in[B_OVERFLOW_IRQ_ENABLE];
      sc_nxt[B_CENTER_ALIGNED_SELECT] = pwdata_in[B_CENTER_ALIGNED_SELECT];
      if (!pwdata_in[B_TOF]) sc_nxt[B_TOF] = 1'b0;
    end
    if (ovf_ev) sc_nxt[B_TOF] = 1'b1;
    sc_nxt[4:0] = 5'h00;
  end

  // counter state registers
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      sc_r     <= SC_RESET;
      cnt_r    <= CNT_ZERO;
      mod_r    <= MOD_RESET;
      down_r   <= 1'b0;
      cbuf_r   <= CNT_ZERO;
      clk_hi_r <= 1'b0;
      clk_lo_r <= 1'b0;
    end else begin
      sc_r     <= sc_nxt;
      cnt_r    <= cnt_nxt;
      mod_r    <= mod_nxt;
      down_r   <= down_nxt;
      cbuf_r   <= cbuf_nxt;
      clk_hi_r <= clk_hi_nxt;
      clk_lo_r <= clk_lo_nxt;
    end
  end

  // per-channel capture state: control byte, captured value and the
  // coherent read buffer with its byte-read markers
  logic [7:0]  csc_r  [NCH];
  logic [7:0]  csc_nxt[NCH];
  logic [15:0] cval_r [NCH];
  logic [15:0] cval_nxt[NCH];
  logic [15:0] vbuf_r [NCH];
  logic [15:0] vbuf_nxt[NCH];
  logic        vhi_r  [NCH];
  logic        vhi_nxt[NCH];
  logic        vlo_r  [NCH];
  logic        vlo_nxt[NCH];
  logic [NCH-1:0] pin_d_r;
  logic [NCH-1:0] cap_ev;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      tc_mode_e mode;
      logic     rise;
      logic     fall;
      assign mode = tc_mode_e'({csc_r[g][B_MSB], csc_r[g][B_MSA]});
      // edges against the last sample of the pin
      assign rise = event_pin_in[g] && !pin_d_r[g];
      assign fall = !event_pin_in[g] && pin_d_r[g];
      // edge select: 01 rising, 10 falling, 11 either
      assign cap_ev[g] = !center_aligned_select && (mode == TC_MODE_CAPTURE) &&
                         ((csc_r[g][B_ELSA] && rise) ||
                          (csc_r[g][B_ELSB] && fall));


      // capture, coherent value reads and status writes
      always_comb begin
        csc_nxt[g]  = csc_r[g];
        cval_nxt[g] = cval_r[g];
        vbuf_nxt[g] = vbuf_r[g];
        vhi_nxt[g]  = vhi_r[g];
        vlo_nxt[g]  = vlo_r[g];
        // latch the count seen in the edge cycle
        if (cap_ev[g]) cval_nxt[g] = cnt_r;
        if (rd && ch_hit(paddr_in, g, A_CH_VAL_HI)) begin
          if (!vhi_r[g] && !vlo_r[g]) vbuf_nxt[g] = cval_r[g];
          vhi_nxt[g] = 1'b1;
        end
        if (rd && ch_hit(paddr_in, g, A_CH_VAL_LO)) begin
          if (!vhi_r[g] && !vlo_r[g]) vbuf_nxt[g] = cval_r[g];
          vlo_nxt[g] = 1'b1;
        end
        if (vhi_nxt[g] && vlo_nxt[g]) begin
          vhi_nxt[g] = 1'b0;
          vlo_nxt[g] = 1'b0;
        end

        // value bytes may also be preset by software
        if (wr && ch_hit(paddr_in, g, A_CH_VAL_HI))
          cval_nxt[g][15:8] = pwdata_in[7:0];
        if (wr && ch_hit(paddr_in, g, A_CH_VAL_LO))
          cval_nxt[g][7:0] = pwdata_in[7:0];
        if (wr && ch_hit(paddr_in, g, A_CH_SC)) begin
          csc_nxt[g][6:2] = pwdata_in[6:2];
          if (!pwdata_in[B_CHF]) csc_nxt[g][B_CHF] = 1'b0;
          vhi_nxt[g] = 1'b0;
          vlo_nxt[g] = 1'b0;
        end
        if (cap_ev[g]) csc_nxt[g][B_CHF] = 1'b1;
        csc_nxt[g][1:0] = 2'b00;
      end


      // channel registers
      always_ff @(posedge clk_in) begin
        if (reset_in) begin
          csc_r[g]  <= SC_RESET;
          cval_r[g] <= CNT_ZERO;
          vbuf_r[g] <= CNT_ZERO;
          vhi_r[g]  <= 1'b0;
          vlo_r[g]  <= 1'b0;
        end else begin
          csc_r[g]  <= csc_nxt[g];
          cval_r[g] <= cval_nxt[g];
          vbuf_r[g] <= vbuf_nxt[g];
          vhi_r[g]  <= vhi_nxt[g];
          vlo_r[g]  <= vlo_nxt[g];
        end
      end
    end
  endgenerate

  // bus read mux; unmapped reads zero with slave error
  // decoded at the setup edge, when the answer byte is latched
  logic [31:0] rdata;
  logic        rerr;
  logic [15:0] cnt_view;
  // a pending snapshot hides the live count
  assign cnt_view = (clk_hi_r || clk_lo_r) ? cbuf_r : cnt_r;
  always_comb begin
    rdata = 32'h0000_0000;
    rerr  = 1'b1;
    case (paddr_in)
      A_STATUS_CTRL: begin
        rdata[7:0] = sc_r;
        rerr       = 1'b0;
      end
      A_COUNT_HI: begin
        rdata[7:0] = cnt_view[15:8];
        rerr       = 1'b0;
      end
      A_COUNT_LO: begin
        rdata[7:0] = cnt_view[7:0];
        rerr       = 1'b0;
      end
      A_MOD_HI: begin
        rdata[7:0] = mod_r[15:8];
        rerr       = 1'b0;
      end
      A_MOD_LO: begin
        rdata[7:0] = mod_r[7:0];
        rerr       = 1'b0;
      end
      default: begin
        // channel registers, three per channel block
        for (int n = 0; n < NCH; n++) begin
          if (ch_hit(paddr_in, n, A_CH_SC)) begin
            rdata[7:0] = csc_r[n];
            rerr       = 1'b0;
          end
          if (ch_hit(paddr_in, n, A_CH_VAL_HI)) begin
            rdata[7:0] = (vhi_r[n] || vlo_r[n]) ? vbuf_r[n][15:8]
                                                : cval_r[n][15:8];
            rerr       = 1'b0;
          end
          if (ch_hit(paddr_in, n, A_CH_VAL_LO)) begin
            rdata[7:0] = (vhi_r[n] || vlo_r[n]) ? vbuf_r[n][7:0]
                                                : cval_r[n][7:0];
            rerr       = 1'b0;
          end
        end
      end
    endcase
  end

  // channel interrupt levels from next flag and enable
  logic [NCH-1:0] chirq_nxt;
  always_comb begin
    for (int n = 0; n < NCH; n++)
      chirq_nxt[n] = csc_nxt[n][B_CHF] && csc_nxt[n][B_CHIE];
  end


  // bus answer: one cycle of pready in the access phase, data from setup
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      prdata_out  <= 32'h0000_0000;
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
    end else begin
      prdata_out  <= rd ? rdata : prdata_out;
      pready_out  <= psel_in && !penable_in;
      pslverr_out <= psel_in && !penable_in && rerr;
    end
  end

  // interrupt levels and count view follow next-cycle state, so each
  // output matches the register it mirrors in the same cycle
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      overflow_irq_out <= 1'b0;
      channel_irq_out  <= '0;
      count_out        <= CNT_ZERO;
    end else begin
      overflow_irq_out <= sc_nxt[B_TOF] && sc_nxt[B_OVERFLOW_IRQ_ENABLE];
      channel_irq_out  <= chirq_nxt;
      count_out        <= cnt_nxt;
    end
  end

  // pin history for edge detection; resets low, like an idle pin
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pin_d_r <= '0;
    end else begin
      pin_d_r <= event_pin_in;
    end
  end
endmodule : tcap_timer
`default_nettype wire

//--- testbench/tcap_timer_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module tcap_timer_monitor (
  input wire logic                     clk_in,
  input wire logic                     reset_in,
  input wire logic [7:0]               paddr_in,
  input wire logic                     psel_in,
  input wire logic                     penable_in,
  input wire logic                     pwrite_in,
  input wire logic [31:0]              pwdata_in,
  input wire logic [31:0]              prdata_out,
  input wire logic                     pready_out,
  input wire logic                     pslverr_out,
  input wire logic [tcap_pkg::NCH-1:0] event_pin_in,
  input wire logic                     overflow_irq_out,
  input wire logic [tcap_pkg::NCH-1:0] channel_irq_out,
  input wire logic [15:0]              count_out
);
  import tcap_pkg::*;
  logic wr_c;
  // a register write completing in this cycle
  assign wr_c = psel_in && penable_in && pwrite_in;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  // bus answer, counter stepping, flag release
  a_ready_access: assert property (pready_out |-> psel_in && penable_in)
    else $error("pready outside access");
  a_ready_single: assert property (pready_out |=> !pready_out)
    else $error("pready held");
  a_err_ready: assert property (pslverr_out |-> pready_out)
    else $error("pslverr without pready");
  a_rdata_upper: assert property (pready_out |-> prdata_out[31:8] == 24'h0)
    else $error("upper read bits set");
  a_count_step: assert property (!$past(reset_in) && count_out != 0
    |-> count_out - $past(count_out) inside {16'h0001, 16'hffff})
    else $error("counter jumped");
  a_zero_single: assert property (count_out == CNT_ZERO && !wr_c
    && !$past(reset_in) |=> count_out == 16'h0001)
    else $error("zero count not one cycle");
  a_ovf_release: assert property ($fell(overflow_irq_out)
    |-> $past(wr_c) || $past(wr_c, 2))
    else $error("overflow irq dropped without write");
  a_chan_release: assert property ($fell(channel_irq_out[0])
    |-> $past(wr_c) || $past(wr_c, 2))
    else $error("channel irq dropped without write");
  c_slverr: cover property (pslverr_out);
  c_ovf_drop: cover property ($fell(overflow_irq_out));
  c_chan_irq: cover property ($rose(channel_irq_out[0]));
endmodule : tcap_timer_monitor
bind tcap_timer tcap_timer_monitor i_tcap_timer_monitor (.clk_in, .reset_in,
  .paddr_in, .psel_in, .penable_in, .pwrite_in, .pwdata_in, .prdata_out,
  .pready_out, .pslverr_out, .event_pin_in, .overflow_irq_out,
  .channel_irq_out, .count_out);
`default_nettype wire

//--- testbench/tcap_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module tcap_pin_model (
  input  wire logic                     clk_in,
  input  wire logic [15:0]              count_in,
  output var  logic [tcap_pkg::NCH-1:0] pin_out,
  output var  logic [15:0]              seen_out
);
  import tcap_pkg::*;
  initial pin_out = '0;
  initial seen_out = CNT_ZERO;
  // one pin change; note the count in the cycle the block samples it
  task automatic flip();
    @(posedge clk_in);
    pin_out[0] <= ~pin_out[0];
    @(posedge clk_in);
    seen_out = count_in;
    repeat (3) @(posedge clk_in);
  endtask : flip
endmodule : tcap_pin_model
`default_nettype wire

//--- testbench/tb_tcap_timer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_tcap_timer;
  import tcap_pkg::*;
  logic           clk_in = 1'b0, reset_in = 1'b1, up, err_bit;
  logic           psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic [7:0]     paddr_in = 8'h00, rd;
  logic [31:0]    pwdata_in = 32'h0, prdata_out;
  logic           pready_out, pslverr_out, overflow_irq_out;
  logic [NCH-1:0] event_pin_in, channel_irq_out;
  logic [15:0]    count_out, snap, seen, exp_v, v;
  logic [7:0]     cfg [4] = '{8'h44, 8'h08, 8'h0c, 8'h1c};
  int             err_total = 0, cmp_count = 0, cyc = 0;
  always #2 clk_in = ~clk_in;
  tcap_timer i_tcap_timer (.clk_in(clk_in), .reset_in(reset_in),
    .paddr_in(paddr_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
    .pready_out(pready_out), .pslverr_out(pslverr_out),
    .event_pin_in(event_pin_in), .overflow_irq_out(overflow_irq_out),
    .channel_irq_out(channel_irq_out), .count_out(count_out));
  tcap_pin_model i_tcap_pin_model (.clk_in(clk_in), .count_in(count_out),
    .pin_out(event_pin_in), .seen_out(seen));
  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one bus transfer; keeps read byte, error bit, count seen at setup
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= {24'h0, d};
    @(posedge clk_in);
    snap = count_out;
    penable_in <= 1'b1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    rd = prdata_out[7:0];
    err_bit = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  // hang guard
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      give_verdict();
    end
  end
  task automatic t_wrap();
    apb(0, 8'h14, 8'h00);
    chk({15'h0, err_bit}, 16'h1);
    apb(1, A_MOD_LO, 8'h05);
    apb(1, A_STATUS_CTRL, 8'h40);
    apb(1, A_COUNT_LO, 8'h33);
    exp_v = CNT_ZERO;
    repeat (9) begin
      @(posedge clk_in);
      chk(count_out, exp_v);
      exp_v = (exp_v == 16'h5) ? CNT_ZERO : exp_v + 16'h1;
    end
    chk({15'h0, overflow_irq_out}, 16'h1);
    apb(1, A_STATUS_CTRL, 8'h00);
    repeat (8) @(posedge clk_in);
    chk({15'h0, overflow_irq_out}, 16'h0);
    apb(0, A_STATUS_CTRL, 8'h00);
    chk({8'h0, rd}, 16'h80);
  endtask : t_wrap
  task automatic t_center();
    apb(1, A_COUNT_HI, 8'h00);
    apb(1, A_STATUS_CTRL, 8'h20);
    exp_v = 16'h3;
    up = 1'b1;
    repeat (14) begin
      @(posedge clk_in);
      chk(count_out, exp_v);
      if (exp_v == 16'h5) up = 1'b0;
      if (exp_v == CNT_ZERO) up = 1'b1;
      exp_v = up ? exp_v + 16'h1 : exp_v - 16'h1;
    end
    apb(0, A_STATUS_CTRL, 8'h00);
    chk({8'h0, rd}, 16'ha0);
  endtask : t_center
  task automatic t_snap();
    apb(1, A_STATUS_CTRL, 8'h00);
    apb(1, A_MOD_LO, 8'h00);
    repeat (300) @(posedge clk_in);
    apb(0, A_COUNT_HI, 8'h00);
    v = snap;
    chk({8'h0, rd}, {8'h0, v[15:8]});
    repeat (20) @(posedge clk_in);
    apb(0, A_COUNT_LO, 8'h00);
    chk({8'h0, rd}, {8'h0, v[7:0]});
    apb(0, A_COUNT_LO, 8'h00);
    apb(1, A_COUNT_HI, 8'h5a);
    apb(0, A_COUNT_HI, 8'h00);
    chk({8'h0, rd}, 16'h0000);
  endtask : t_snap
  task automatic t_capture();
    exp_v = CNT_ZERO;
    for (int i = 0; i < 4; i++) begin
      apb(1, A_CH_BASE + A_CH_SC, cfg[i]);
      for (int e = 0; e < 2; e++) begin
        i_tcap_pin_model.flip();
        if (cfg[i][5:4] == 2'b00 && cfg[i][2 + e]) exp_v = seen;
        apb(0, A_CH_BASE + A_CH_VAL_HI, 8'h00);
        v[15:8] = rd;
        apb(0, A_CH_BASE + A_CH_VAL_LO, 8'h00);
        v[7:0] = rd;
        chk(v, exp_v);
      end
      apb(0, A_CH_BASE + A_CH_SC, 8'h00);
      chk({15'h0, rd[7]}, {15'h0, cfg[i][5:4] == 2'b00});
      if (i == 0) chk({15'h0, channel_irq_out[0]}, 16'h1);
    end
  endtask : t_capture
  initial begin
    repeat (5) @(posedge clk_in);
    reset_in <= 1'b0;
    t_wrap();
    t_center();
    t_snap();
    t_capture();
    give_verdict();
  end
endmodule : tb_tcap_timer
`default_nettype wire
